// ---- common/fpu_ipc_pkg.sv ----
// Purpose: constants, types and helpers of the inner product / load / convert unit
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes: Functional notes below
// Functional notes
// RULE1: with double_select_bit clear, inner product of two vectors goes to dest slot 3.
// RULE2: vector operands are registers 0-3, 4-7, 8-11, 12-15 chosen by two bits.
// RULE3: four element products formed in parallel, each kept to 28 bits.
// RULE4: products aligned to common exponent, each rounded to fit 30 bits.
// RULE5: aligned values summed, then normalised and rounded to single precision.
// RULE6: any signalling nan input to the inner product raises invalid.
// RULE7: zero times infinity in any multiplicand pair raises invalid.
// RULE8: otherwise a quiet nan input gives a quiet nan result.
// RULE9: infinite products of differing sign raise invalid, else signed infinity stored.
// RULE10: inner product traps when O, U or I enabled; trap keeps destination unchanged.
// RULE11: load zero writes 0x00000000 to the selected register in one state.
// RULE12: load one writes 0x3f800000 to the selected register in one state.
// RULE13: move copies the register to comm register unchanged, no checks, no exception.
// RULE14: single conversion turns the 32-bit comm integer into single precision.
// RULE15: double conversion writes the register pair and takes two states.
// RULE16: conversion traps when inexact enabled; trap keeps destination unchanged.
// RULE17: double conversion never signals inexact.
// RULE18: reserved forms act as undefined operations and produce no result.
// RULE19: with denormal_flush_bit set, denormal inputs count as signed zero.
// RULE20: single conversion sets inexact when bits are lost, rounding per mode.
// RULE21: conversion and inner product clear cause before recording new exceptions.
// RULE22: constant loads and move keep cause and flag and never trap.
package fpu_ipc_pkg;
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_COMM = 8'h0c;
  localparam logic [7:0] OFS_FR = 8'h40;
  localparam logic [7:0] OFS_FR_END = 8'h7c;
  localparam int CTL_RM = 0;
  localparam int CTL_FLAG = 1;
  localparam int CTL_EN = 7;
  localparam int CTL_CAUSE = 13;
  localparam int CTL_FLUSH = 19;
  localparam int CTL_DBL = 20;
  localparam int CAUSE_W = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h001f_ffff;
  localparam int C_I = 0;
  localparam int C_U = 1;
  localparam int C_O = 2;
  localparam int C_Z = 3;
  localparam int C_V = 4;
  localparam int C_E = 5;
  localparam int ST_BUSY = 0;
  localparam int ST_TRAP = 1;
  localparam int ST_UNDEF = 2;
  localparam logic [3:0] OP_PREFIX = 4'hf;
  localparam logic [7:0] SUF_IPR = 8'hed;
  localparam logic [7:0] SUF_LD0 = 8'h8d;
  localparam logic [7:0] SUF_LD1 = 8'h9d;
  localparam logic [7:0] SUF_MOV = 8'h1d;
  localparam logic [7:0] SUF_FLT = 8'h2d;
  localparam logic [31:0] FP_ZERO = 32'h0000_0000;
  localparam logic [31:0] FP_ONE = 32'h3f80_0000;
  localparam logic [31:0] FP_QNAN = 32'h7fbf_ffff;
  localparam logic [31:0] FP_INF_ABS = 32'h7f80_0000;
  localparam logic [31:0] QNAN_LIMIT = 32'h7fc0_0000;
  localparam logic [31:0] DENORM_LIMIT = 32'h0080_0000;
  localparam logic [30:0] FP_MAX_ABS = 31'h7f7f_ffff;
  localparam int SP_BIAS = 127;
  localparam int DP_BIAS = 1023;
  localparam int SP_EMAX = 255;
  localparam int PROD_W = 28;
  localparam int ALIGN_W = 30;
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_EXEC = 3'b010, ST_WAIT = 3'b100} state_t;
  typedef enum logic [2:0] {K_ZERO, K_NORM, K_DENORM, K_INF, K_QNAN, K_SNAN} kind_t;

  // class of a single value, flushing denormals when asked
  function automatic kind_t classify(input logic [31:0] v, input logic flush);
    logic [31:0] mag;
    mag = {1'b0, v[30:0]};
    if (mag < DENORM_LIMIT) return (flush || mag == FP_ZERO) ? K_ZERO : K_DENORM; // RULE19
    else if (mag < FP_INF_ABS) return K_NORM;
    else if (mag == FP_INF_ABS) return K_INF;
    else if (mag < QNAN_LIMIT) return K_QNAN;
    else return K_SNAN;
  endfunction

  // round to nearest even, or truncate when rm_zero
  function automatic logic round_inc(input logic lsb, input logic rnd, input logic stk,
                                     input logic rm_zero);
    return !rm_zero && rnd && (stk || lsb);
  endfunction
endpackage

// ---- common/fp_res_if.sv ----
// Purpose: result and exception cause carried from a datapath to the control
// Assumes: one clock, purely combinational contents
// Notes: value low word holds single results, full word double results
`timescale 1ns/1ps
`default_nettype none
interface fp_res_if;
  logic [63:0] value;
  logic [5:0] cause;
  modport src (output value, output cause);
  modport dst (input value, input cause);
endinterface
`default_nettype wire

// ---- verilog/fp_dot4.sv ----
// Purpose: four-element single precision inner product with special cases
// Assumes: operands stable while the control commits
// Notes: combinational
`timescale 1ns/1ps
`default_nettype none
module fp_dot4 (
  input wire logic [3:0][31:0] a,
  input wire logic [3:0][31:0] b,
  input wire logic flush,
  input wire logic rm_zero,
  fp_res_if.src res
);
  import fpu_ipc_pkg::*;
  kind_t ka [4];
  kind_t kb [4];
  logic [47:0] mp [4];
  logic [PROD_W-1:0] pm [4];
  logic [9:0] pe [4];
  logic [3:0] live, ps, zinf, pinf, snan, qnan, den;
  logic [9:0] emax;
  logic [33:0] sum, mag;
  logic [5:0] lead;
  logic [33:0] nrm;
  logic [23:0] rfr;
  logic [11:0] e2;
  logic s, inc, rnd, stk, any_pos_inf, any_neg_inf;

  for (genvar i = 0; i < 4; i++) begin : g_el
    assign ka[i] = classify(a[i], flush);
    assign kb[i] = classify(b[i], flush);
    assign mp[i] = {1'b1, a[i][22:0]} * {1'b1, b[i][22:0]};
    assign pm[i] = mp[i][47] ? mp[i][47:20] : mp[i][46:19]; // RULE3
    assign pe[i] = 10'(a[i][30:23]) + 10'(b[i][30:23]) + 10'(mp[i][47]);
    assign live[i] = ka[i] == K_NORM && kb[i] == K_NORM;
    assign ps[i] = a[i][31] ^ b[i][31];
    assign zinf[i] = (ka[i] == K_ZERO && kb[i] == K_INF) || (ka[i] == K_INF && kb[i] == K_ZERO);
    assign pinf[i] = ka[i] == K_INF || kb[i] == K_INF;
    assign snan[i] = ka[i] == K_SNAN || kb[i] == K_SNAN;
    assign qnan[i] = ka[i] == K_QNAN || kb[i] == K_QNAN;
    assign den[i] = ka[i] == K_DENORM || kb[i] == K_DENORM;
  end

  always_comb begin
    logic [59:0] wide;
    logic [30:0] al;
    wide = '0;
    al = '0;
    emax = '0;
    sum = '0;
    any_pos_inf = 1'b0;
    any_neg_inf = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (live[i] && pe[i] > emax) emax = pe[i];
      if (pinf[i] && !ps[i]) any_pos_inf = 1'b1;
      if (pinf[i] && ps[i]) any_neg_inf = 1'b1;
    end
    for (int i = 0; i < 4; i++) begin
      wide = {pm[i], 2'b00, 30'h0} >> (emax - pe[i]);
      al = {1'b0, wide[59:30]} + 31'(wide[29]); // RULE4
      if (live[i]) sum = ps[i] ? sum - 34'(al) : sum + 34'(al); // RULE5
    end
    s = sum[33];
    mag = s ? 34'(-sum) : sum;
    lead = '0;
    for (int j = 0; j < 33; j++) if (mag[j]) lead = 6'(j);
    nrm = mag << (6'd32 - lead);
    rnd = nrm[8];
    stk = |nrm[7:0];
    inc = round_inc(nrm[9], rnd, stk, rm_zero);
    rfr = {1'b0, nrm[31:9]} + 24'(inc);
    e2 = 12'(emax) + 12'(lead) + 12'(rfr[23]) - 12'(SP_BIAS) - 12'(ALIGN_W - 1);
    res.value = '0;
    res.cause = '0;
    if (|snan || |zinf) begin // RULE6 RULE7
      res.cause[C_V] = 1'b1;
      res.value[31:0] = FP_QNAN;
    end else if (|qnan) begin
      res.value[31:0] = FP_QNAN; // RULE8
    end else if (|pinf) begin
      if (any_pos_inf && any_neg_inf) begin // RULE9
        res.cause[C_V] = 1'b1;
        res.value[31:0] = FP_QNAN;
      end else res.value[31:0] = {any_neg_inf, FP_INF_ABS[30:0]}; // RULE9
    end else if (|den) begin
      res.cause[C_E] = 1'b1;
    end else if (mag != '0) begin
      if ($signed(e2) >= SP_EMAX) begin
        res.cause[C_O] = 1'b1;
        res.cause[C_I] = 1'b1;
        res.value[31:0] = {s, rm_zero ? FP_MAX_ABS : FP_INF_ABS[30:0]};
      end else if ($signed(e2) <= 0) begin
        res.cause[C_U] = 1'b1;
        res.cause[C_I] = 1'b1;
        res.value[31:0] = {s, 31'h0};
      end else begin
        res.cause[C_I] = rnd || stk;
        res.value[31:0] = {s, e2[7:0], rfr[23] ? 23'h0 : rfr[22:0]}; // RULE5
      end
    end
  end
endmodule // fp_dot4
`default_nettype wire

// ---- verilog/fp_from_int.sv ----
// Purpose: 32-bit signed integer to single or double precision
// Assumes: rounding mode nearest-even or toward zero
// Notes: combinational
`timescale 1ns/1ps
`default_nettype none
module fp_from_int (
  input wire logic [31:0] comm,
  input wire logic dbl,
  input wire logic rm_zero,
  fp_res_if.src res
);
  import fpu_ipc_pkg::*;
  logic s, inc;
  logic [31:0] mag, nrm;
  logic [4:0] lead;
  logic [23:0] rfr;

  always_comb begin
    s = comm[31];
    mag = s ? 32'(-comm) : comm;
    lead = '0;
    for (int j = 0; j < 32; j++) if (mag[j]) lead = 5'(j);
    nrm = mag << (5'd31 - lead);
    inc = round_inc(nrm[8], nrm[7], |nrm[6:0], rm_zero); // RULE20
    rfr = {1'b0, nrm[30:8]} + 24'(inc);
    res.value = '0;
    res.cause = '0;
    if (mag != '0) begin
      if (dbl) begin
        res.value = {s, 11'(DP_BIAS + 32'(lead)), nrm[30:0], 21'h0}; // RULE15 RULE17
      end else begin
        res.value[31:0] = {s, 8'(SP_BIAS + 32'(lead) + 32'(rfr[23])), rfr[22:0]}; // RULE14
        res.cause[C_I] = nrm[7] || (|nrm[6:0]); // RULE20
      end
    end
  end
endmodule // fp_from_int
`default_nettype wire

// ---- verilog/fpu_ipc_top.sv ----
// Purpose: apb-reached unit for inner product, constant loads, move and integer convert
// Assumes: apb master follows the usual setup/access protocol
// Notes: one instruction at a time; apb stalls while an instruction runs
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fpu_ipc_top #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic trap
);
  import fpu_ipc_pkg::*;

  if (ADDR_W < 8) begin : g_chk
    $error("fpu_ipc_top needs ADDR_W of at least 8");
  end

  state_t state, next_state;
  logic [15:0] op, next_op;
  logic [31:0] ctrl, next_ctrl;
  logic [31:0] comm, next_comm;
  logic [31:0] fr [16];
  logic [31:0] next_fr [16];
  logic undef_flag, next_undef_flag;
  logic trap_flag, next_trap_flag;
  logic next_trap;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;

  fp_res_if dot_res ();
  fp_res_if cnv_res ();

  logic op_ok, is_ipr, is_ld0, is_ld1, is_mov, is_flt, dbl, undef, is_dbl_conv, commit;
  logic [3:0] dst_n, ipr_dst;
  logic [31:0] fr_dst;
  logic [3:0][31:0] va, vb;
  logic [5:0] new_c, enables;
  logic trap_now;
  logic acc, wr, rd;

  // register window decode, shared by read and write paths
  function automatic logic fr_hit(input logic [ADDR_W-1:0] a);
    return a[7:0] >= OFS_FR && a[7:0] <= OFS_FR_END && a[1:0] == 2'b00
           && (ADDR_W == 8 || a >= ADDR_W'(OFS_FR));
  endfunction

  function automatic logic [3:0] fr_idx(input logic [ADDR_W-1:0] a);
    return 4'(a[5:2]);
  endfunction

  function automatic logic at(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    return a == ADDR_W'(ofs);
  endfunction

  // instruction decode
  assign op_ok = op[15:12] == OP_PREFIX;
  assign is_ipr = op_ok && op[7:0] == SUF_IPR;
  assign is_ld0 = op_ok && op[7:0] == SUF_LD0;
  assign is_ld1 = op_ok && op[7:0] == SUF_LD1;
  assign is_mov = op_ok && op[7:0] == SUF_MOV;
  assign is_flt = op_ok && op[7:0] == SUF_FLT;
  assign dbl = ctrl[CTL_DBL];
  assign undef = !(is_ipr || is_ld0 || is_ld1 || is_mov || is_flt) // RULE18
                 || (dbl && (is_ipr || is_ld0 || is_ld1)) // RULE18
                 || (dbl && is_flt && op[8]); // RULE18
  assign is_dbl_conv = is_flt && dbl && !undef;
  assign dst_n = op[11:8];
  assign ipr_dst = {op[11:10], 2'b11}; // RULE1
  assign fr_dst = fr[dst_n];
  assign commit = (state == ST_EXEC && !is_dbl_conv) || state == ST_WAIT; // RULE15

  for (genvar k = 0; k < 4; k++) begin : g_vec
    assign va[k] = fr[{op[11:10], 2'(k)}]; // RULE2
    assign vb[k] = fr[{op[9:8], 2'(k)}]; // RULE2
  end

  fp_dot4 u_dot (
    .a(va),
    .b(vb),
    .flush(ctrl[CTL_FLUSH]),
    .rm_zero(ctrl[CTL_RM]),
    .res(dot_res.src)
  );

  fp_from_int u_cnv (
    .comm(comm),
    .dbl(dbl),
    .rm_zero(ctrl[CTL_RM]),
    .res(cnv_res.src)
  );

  // exception and trap decision
  assign new_c = is_ipr ? dot_res.cause : cnv_res.cause;
  assign enables = ctrl[CTL_EN +: CAUSE_W];
  assign trap_now = (|(new_c & enables)) || new_c[C_E]
                    || (is_ipr && (enables[C_O] || enables[C_U] || enables[C_I])) // RULE10
                    || (is_flt && enables[C_I]); // RULE16

  // apb handshake
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;

  always_comb begin
    next_pready = psel && penable && !pready && state == ST_IDLE;
    next_prdata = '0;
    next_pslverr = 1'b0;
    if (next_pready) begin
      if (at(paddr, OFS_CMD)) next_prdata = {16'h0, op};
      else if (at(paddr, OFS_CTRL)) next_prdata = ctrl;
      else if (at(paddr, OFS_STAT)) next_prdata = {29'h0, undef_flag, trap_flag, 1'b0};
      else if (at(paddr, OFS_COMM)) next_prdata = comm;
      else if (fr_hit(paddr)) next_prdata = pwrite ? '0 : fr[fr_idx(paddr)];
      else next_pslverr = 1'b1;
    end
  end

  // control, register file and execution
  always_comb begin
    next_state = state;
    next_op = op;
    next_ctrl = ctrl;
    next_comm = comm;
    next_fr = fr;
    next_undef_flag = undef_flag;
    next_trap_flag = trap_flag;
    next_trap = 1'b0;
    case (state)
      ST_IDLE: begin
        if (wr && at(paddr, OFS_CMD)) begin
          next_op = pwdata[15:0];
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        next_state = is_dbl_conv ? ST_WAIT : ST_IDLE; // RULE15
      end
      ST_WAIT: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (wr && at(paddr, OFS_CTRL)) next_ctrl = pwdata & CTRL_MASK;
    if (wr && at(paddr, OFS_COMM)) next_comm = pwdata;
    if (wr && fr_hit(paddr)) next_fr[fr_idx(paddr)] = pwdata;
    if (commit) begin
      next_undef_flag = undef; // RULE18
      next_trap_flag = 1'b0;
      if (!undef) begin
        if (is_ld0) next_fr[dst_n] = FP_ZERO; // RULE11 RULE22
        if (is_ld1) next_fr[dst_n] = FP_ONE; // RULE12 RULE22
        if (is_mov) next_comm = fr_dst; // RULE13 RULE22
        if (is_ipr || is_flt) begin
          next_ctrl[CTL_CAUSE +: CAUSE_W] = new_c; // RULE21
          next_ctrl[CTL_FLAG +: CAUSE_W] = ctrl[CTL_FLAG +: CAUSE_W] | new_c;
          next_trap_flag = trap_now;
          next_trap = trap_now;
          if (!trap_now) begin // RULE10 RULE16
            if (is_ipr) next_fr[ipr_dst] = dot_res.value[31:0]; // RULE1
            else if (is_dbl_conv) begin
              next_fr[{op[11:9], 1'b0}] = cnv_res.value[63:32]; // RULE15
              next_fr[{op[11:9], 1'b1}] = cnv_res.value[31:0]; // RULE15
            end else next_fr[dst_n] = cnv_res.value[31:0]; // RULE14
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      op <= '0;
      ctrl <= CTRL_RESET;
      comm <= '0;
      fr <= '{default: '0};
      undef_flag <= 1'b0;
      trap_flag <= 1'b0;
      trap <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      ctrl <= next_ctrl;
      comm <= next_comm;
      fr <= next_fr;
      undef_flag <= next_undef_flag;
      trap_flag <= next_trap_flag;
      trap <= next_trap;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_dbl_steps;
    state == ST_WAIT ##1 state == ST_IDLE;
  endsequence

  a_load_zero_value: assert property ( // RULE11
    (state == ST_EXEC && is_ld0 && !undef) |=> fr[$past(dst_n)] == FP_ZERO)
    else $error("load zero did not write zero");

  a_load_one_value: assert property ( // RULE12
    (state == ST_EXEC && is_ld1 && !undef) |=> fr[$past(dst_n)] == FP_ONE && state == ST_IDLE)
    else $error("load one did not write one in one state");

  a_move_copies_reg: assert property ( // RULE13
    (state == ST_EXEC && is_mov) |=> comm == $past(fr_dst) && !trap)
    else $error("move did not copy register");

  a_dbl_conv_two: assert property ( // RULE15
    (state == ST_EXEC && is_dbl_conv) |=> s_dbl_steps)
    else $error("double conversion not two states");

  a_dbl_no_inexact: assert property ( // RULE17
    (state == ST_WAIT) |=> !ctrl[CTL_CAUSE + C_I])
    else $error("double conversion signalled inexact");

  a_undef_no_result: assert property ( // RULE18
    (state == ST_EXEC && undef) |=> undef_flag && $stable(comm) && $stable(ctrl) && !trap)
    else $error("undefined form changed state");

  a_load_keeps_cause: assert property ( // RULE22
    (state == ST_EXEC && (is_ld0 || is_ld1 || is_mov)) |=> $stable(ctrl) && !trap)
    else $error("load or move touched cause or trapped");

  a_ipr_always_trap: assert property ( // RULE10
    (commit && is_ipr && !undef && (enables[C_O] || enables[C_U] || enables[C_I]))
      |=> trap && trap_flag)
    else $error("inner product did not trap with enable set");

  a_trap_keeps_dest: assert property ( // RULE16
    (commit && is_flt && !dbl && trap_now) |=> fr[$past(dst_n)] == $past(fr_dst))
    else $error("trapped conversion wrote destination");

  a_cause_cleared: assert property ( // RULE21
    (commit && (is_ipr || is_flt) && !undef && new_c == '0) |=> ctrl[CTL_CAUSE +: CAUSE_W] == '0)
    else $error("cause not cleared");
endmodule // fpu_ipc_top
`default_nettype wire

// ---- bench/apb_issue_model.sv ----
// Purpose: issue-side model that hands opcodes and register traffic over apb
// Assumes: one transfer at a time; waits on pready with no limit of its own
// Notes: released address and data lines are inverted so no stale value lingers
`timescale 1ns/1ps
`default_nettype none
module apb_issue_model (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // setup, access, then hold until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // apb_issue_model
`default_nettype wire

// ---- bench/fpu_inner_product_load_convert_bench.sv ----
// Purpose: self-checking bench of the inner product / load / convert unit
// Assumes: unit reached over apb through the issue model
// Notes: trap pulses are counted by a monitor
`timescale 1ns/1ps
`default_nettype none
module fpu_inner_product_load_convert_bench;
  import fpu_ipc_pkg::*;
  typedef struct packed {
    logic [31:0] a0, a1, b0, ctl, res;
    logic [7:0] cause;
    logic tr;
  } dcase_t;
  localparam logic [31:0] SNAN = 32'h7fc0_0000;
  localparam logic [31:0] DBL = 32'h0010_0000;
  localparam logic [7:0] SKIP = 8'hff;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, trap;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int err_count = 0;
  int n_tests = 0;
  int trap_cnt = 0;
  logic [15:0] rsv [4] = '{16'hf52d, 16'hf09d, 16'hf4ed, 16'hf003};
  dcase_t dc [12] = '{
    '{32'h4000_0000, 32'h4040_0000, 32'h4080_0000, 32'h0, 32'h4150_0000, 8'h00, 1'b0},
    '{SNAN, FP_ONE, FP_ONE, 32'h0, FP_QNAN, 8'h10, 1'b0},
    '{32'h0, FP_ONE, FP_INF_ABS, 32'h0, FP_QNAN, 8'h10, 1'b0},
    '{32'h7f80_0001, FP_ONE, FP_ONE, 32'h0, FP_QNAN, 8'h00, 1'b0},
    '{FP_INF_ABS, 32'hff80_0000, FP_ONE, 32'h0, FP_QNAN, 8'h10, 1'b0},
    '{FP_INF_ABS, FP_INF_ABS, FP_ONE, 32'h0, FP_INF_ABS, 8'h00, 1'b0},
    '{SNAN, FP_ONE, FP_ONE, 32'h800, FP_ONE, 8'h10, 1'b1},
    '{32'hbf80_0000, 32'h0, FP_ONE, 32'h200, FP_ONE, 8'h00, 1'b1},
    '{32'h1, FP_ONE, FP_ONE, 32'h8_0000, 32'h4040_0000, 8'h00, 1'b0},
    '{32'h1, FP_ONE, FP_ONE, 32'h0, FP_ONE, 8'h20, 1'b1},
    '{FP_ONE, FP_ONE, 32'h3080_0000, 32'h0, 32'h4040_0000, SKIP, 1'b0},
    '{32'h7f00_0000, FP_ONE, 32'h7f00_0000, 32'h0, FP_INF_ABS, 8'h05, 1'b0}
  };

  fpu_ipc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trap(trap));
  apb_issue_model model (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  initial begin
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (trap === 1'b1) trap_cnt++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] fra(input int i);
    return OFS_FR + 8'(4 * i);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    model.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    model.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    rd(a, q);
    chk(q, exp);
  endtask
  // opcode write, then room for the commit and its trap pulse
  task automatic op(input logic [15:0] code);
    wr(OFS_CMD, {16'h0000, code});
    repeat (4) @(posedge pclk);
  endtask

  task automatic t_reset();
    logic [31:0] q;
    logic e;
    rd_chk(OFS_CTRL, CTRL_RESET);
    rd_chk(OFS_COMM, 32'h0);
    rd_chk(fra(15), 32'h0);
    wr(OFS_STAT, 32'hffff_ffff);
    rd_chk(OFS_STAT, 32'h0);
    model.xfer(1'b0, 8'h10, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    model.xfer(1'b1, 8'h41, 32'h5, q, e);
    chk({31'h0, e}, 32'h1);
    rd_chk(fra(0), 32'h0);
  endtask

  task automatic t_load_move();
    int t0;
    wr(OFS_CTRL, 32'h0002_03fe);
    wr(fra(5), SNAN);
    t0 = trap_cnt;
    op(16'hf51d);
    rd_chk(OFS_COMM, SNAN);
    op(16'hf39d);
    rd_chk(fra(3), FP_ONE);
    op(16'hf38d);
    rd_chk(fra(3), FP_ZERO);
    rd_chk(OFS_CTRL, 32'h0002_03fe);
    chk(32'(trap_cnt - t0), 32'h0);
  endtask

  task automatic t_conv_single();
    logic [31:0] ci [6] = '{32'h3, 32'hffff_ffff, 32'h0100_0001, 32'h0100_0003,
                            32'h0100_0003, 32'h8000_0000};
    logic [31:0] co [6] = '{32'h4040_0000, 32'hbf80_0000, 32'h4b80_0000, 32'h4b80_0002,
                            32'h4b80_0001, 32'hcf00_0000};
    logic [31:0] q;
    logic x;
    for (int i = 0; i < 6; i++) begin
      x = (i >= 2 && i <= 4);
      wr(OFS_CTRL, 32'h0002_0000 | 32'(i == 4));
      wr(OFS_COMM, ci[i]);
      op(16'hf22d);
      rd_chk(fra(2), co[i]);
      rd(OFS_CTRL, q);
      chk({26'h0, q[CTL_CAUSE +: CAUSE_W]}, {31'h0, x});
      chk({31'h0, q[CTL_FLAG + C_I]}, {31'h0, x});
    end
  endtask

  task automatic t_conv_trap();
    int t0;
    wr(OFS_CTRL, 32'h80);
    wr(OFS_COMM, 32'h0100_0001);
    t0 = trap_cnt;
    op(16'hf22d);
    chk(32'(trap_cnt - t0), 32'h1);
    rd_chk(fra(2), 32'hcf00_0000);
    rd_chk(OFS_CTRL, 32'h0000_2082);
    rd_chk(OFS_STAT, 32'h2);
    wr(OFS_COMM, 32'h3);
    t0 = trap_cnt;
    op(16'hf22d);
    chk(32'(trap_cnt - t0), 32'h1);
  endtask

  task automatic t_conv_double();
    int t0;
    wr(OFS_CTRL, DBL);
    wr(OFS_COMM, 32'h0100_0001);
    t0 = trap_cnt;
    op(16'hf42d);
    rd_chk(fra(4), 32'h4170_0000);
    rd_chk(fra(5), 32'h1000_0000);
    rd_chk(OFS_CTRL, DBL);
    foreach (rsv[i]) begin
      op(16'hf42d);
      rd_chk(OFS_STAT, 32'h0);
      op(rsv[i]);
      rd_chk(OFS_STAT, 32'h4);
    end
    rd_chk(fra(5), 32'h1000_0000);
    rd_chk(fra(0), 32'h0);
    rd_chk(fra(7), 32'h0);
    rd_chk(OFS_CTRL, DBL);
    chk(32'(trap_cnt - t0), 32'h0);
  endtask

  task automatic t_dot();
    logic [31:0] q;
    int t0;
    foreach (dc[i]) begin
      for (int r = 0; r < 8; r++) begin
        wr(fra(r), FP_ONE);
      end
      wr(fra(0), dc[i].a0);
      wr(fra(1), dc[i].a1);
      wr(fra(4), dc[i].b0);
      wr(OFS_CTRL, dc[i].ctl);
      t0 = trap_cnt;
      op(16'hf4ed);
      rd_chk(fra(7), dc[i].res);
      chk(32'(trap_cnt - t0), {31'h0, dc[i].tr});
      rd(OFS_CTRL, q);
      if (dc[i].cause != SKIP) begin
        chk({26'h0, q[CTL_CAUSE +: CAUSE_W]}, {24'h0, dc[i].cause});
      end
    end
  endtask

  task automatic t_vectors();
    for (int r = 8; r < 16; r++) begin
      wr(fra(r), FP_ONE);
    end
    wr(fra(8), 32'h4000_0000);
    wr(fra(12), 32'h4040_0000);
    wr(OFS_CTRL, 32'h0);
    op(16'hfeed);
    rd_chk(fra(15), 32'h4110_0000);
  endtask

  task automatic end_of_test();
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_load_move();
    t_conv_single();
    t_conv_trap();
    t_conv_double();
    t_dot();
    t_vectors();
    end_of_test();
  end
  initial begin
    #2000000;
    err_count++;
    end_of_test();
  end
endmodule // fpu_inner_product_load_convert_bench
`default_nettype wire
